// ==== ccu_pkg.sv ====
// package: register map, field layout and modes of the capture/compare unit
package ccu_pkg;
	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] CCU_CTRL     = 12'h000;
	localparam logic [11:0] CCU_TMR_A    = 12'h004;
	localparam logic [11:0] CCU_RLD_A    = 12'h008;
	localparam logic [11:0] CCU_TMR_B    = 12'h00c;
	localparam logic [11:0] CCU_RLD_B    = 12'h010;
	localparam logic [11:0] CCU_CFG_BASE = 12'h040;
	localparam logic [11:0] CCU_VAL_BASE = 12'h080;
	// ---------------------------------------------------------------
	// control fields; time base b sits one stride above time base a
	// ---------------------------------------------------------------
	localparam int          CCU_RUN_A    = 0;
	localparam int          CCU_SEL_A    = 1;
	localparam int          CCU_TB_STEP  = 8;
	localparam int          CCU_STAGGER  = 16;
	localparam logic [31:0] CCU_CTRL_MSK = 32'h0001_0f0f;
	localparam logic [2:0]  CCU_SEL_OVF  = 3'h6;
	localparam logic [2:0]  CCU_SEL_EXT  = 3'h7;
	localparam logic [2:0]  CCU_STAG_PH  = 3'h7;
	// ---------------------------------------------------------------
	// per-channel configuration fields, timer top value and bus response codes
	// ---------------------------------------------------------------
	localparam int          CCU_EDGE_R   = 3;
	localparam int          CCU_EDGE_F   = 4;
	localparam int          CCU_CFG_TB   = 5;
	localparam int          CCU_SINGLE   = 6;
	localparam int          CCU_DBL      = 7;
	localparam logic [15:0] CCU_TMR_TOP  = 16'hffff;
	localparam logic [1:0]  CCU_OKAY     = 2'h0;
	localparam logic [1:0]  CCU_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		CCU_OFF  = 3'h0,
		CCU_CAP  = 3'h1,
		CCU_CMP0 = 3'h2,
		CCU_CMP1 = 3'h3,
		CCU_CMP2 = 3'h4,
		CCU_CMP3 = 3'h5
	} ccu_mode_t;
endpackage

// ==== ccu_capture_compare_unit.sv ====
// top: two reloadable time bases and a capture/compare channel array on AXI4-Lite
// Contract
// - up to 16 channels, one-cycle resolution, eight cycles when staggered
// - two independent 16-bit timers, each with its own reload register
// - timer clock is a prescaled system clock or upstream timer overflow
// - external count input can advance a timer
// - 16 registers, each picks a time base and capture or compare use
// - each register owns one pin: capture input or compare output
// - capture latches the allocated timer and raises that channel's request
// - capture edge per channel: rising, falling or both
// - compare registers match continuously; a match fires the mode's action
// - mode 0: interrupt on every match, many per period
// - mode 1: pin toggles on every match, many per period
// - mode 2: interrupt on match, only once per timer period
// - mode 3: pin high on match, low on overflow, once per period
// - double register: two registers toggle one pin, many per period
// - single event option stops further compare actions after one
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
module ccu_capture_compare_unit #(
	parameter int NCH = 16
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [11:0]      awaddr,
	input  wire logic             awvalid,
	output logic                  awready,
	input  wire logic [31:0]      wdata,
	input  wire logic [3:0]       wstrb,
	input  wire logic             wvalid,
	output logic                  wready,
	output logic [1:0]            bresp,
	output logic                  bvalid,
	input  wire logic             bready,
	input  wire logic [11:0]      araddr,
	input  wire logic             arvalid,
	output logic                  arready,
	output logic [31:0]           rdata,
	output logic [1:0]            rresp,
	output logic                  rvalid,
	input  wire logic             rready,
	input  wire logic             upstream_ovf,
	input  wire logic             ext_count,
	input  wire logic [NCH-1:0]   cc_pin_in,
	output logic [NCH-1:0]        cc_pin_out,
	output logic [NCH-1:0]        cc_pin_oe,
	output logic [NCH-1:0]        cc_irq
);
	localparam int HALF = NCH / 2;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic                 aw_got;
		logic [11:0]          awaddr;
		logic                 w_got;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic [31:0]          ctrl;
		logic [1:0][15:0]     tmr;
		logic [1:0][15:0]     rld;
		logic [1:0]           tick_d;
		logic [7:0]           pre;
		logic [NCH-1:0]       syn1;
		logic [NCH-1:0]       syn2;
		logic [NCH-1:0]       syn3;
		logic [2:0]           ext;
		logic [NCH-1:0][7:0]  cfg;
		logic [NCH-1:0][15:0] val;
		logic [NCH-1:0]       fired;
		logic [NCH-1:0]       done;
		logic [NCH-1:0]       pin;
		logic [NCH-1:0]       irq;
	} ccu_state_t;

	ccu_state_t     s_r;
	ccu_state_t     s_nxt;
	logic [1:0]     ovf;
	logic [1:0]     tk;
	logic [NCH-1:0] trig;
	logic [NCH-1:0] act;
	logic [NCH-1:0] oe;
	logic           wr_do;

	// returns {ok, word} for an aligned address
	function automatic logic [32:0] ccu_rd(input ccu_state_t s, input logic [11:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h0};
		if (a == ccu_pkg::CCU_CTRL)
			r[31:0] = s.ctrl;
		else if (a == ccu_pkg::CCU_TMR_A)
			r[15:0] = s.tmr[0];
		else if (a == ccu_pkg::CCU_RLD_A)
			r[15:0] = s.rld[0];
		else if (a == ccu_pkg::CCU_TMR_B)
			r[15:0] = s.tmr[1];
		else if (a == ccu_pkg::CCU_RLD_B)
			r[15:0] = s.rld[1];
		else if (a[11:6] == ccu_pkg::CCU_CFG_BASE[11:6] && 32'(a[5:2]) < NCH)
			r[7:0] = s.cfg[a[5:2]];
		else if (a[11:6] == ccu_pkg::CCU_VAL_BASE[11:6] && 32'(a[5:2]) < NCH)
			r[15:0] = s.val[a[5:2]];
		else
			r[32] = 1'b0;
		return r;
	endfunction

	function automatic logic [31:0] ccu_merge(input logic [31:0] o, input logic [31:0] d,
			input logic [3:0] st);
		logic [31:0] m;
		m = o;
		for (int k = 0; k < 4; k++)
			if (st[k])
				m[8*k +: 8] = d[8*k +: 8];
		return m;
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [2:0]           sel;
		logic [7:0]           pmask;
		logic                 src;
		ccu_pkg::ccu_mode_t   md;
		logic                 tb;
		logic                 rise;
		logic                 fall;
		logic                 hit;
		logic [11:0]          wa;
		logic [32:0]          rr;
		logic [31:0]          mw;
		sel = 3'h0;
		pmask = 8'h0;
		src = 1'b0;
		md = ccu_pkg::CCU_OFF;
		tb = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		hit = 1'b0;
		wa = {s_r.awaddr[11:2], 2'b00};
		rr = 33'h0;
		mw = 32'h0;
		s_nxt = s_r;
		ovf = 2'b00;
		tk = 2'b00;
		trig = '0;
		act = '0;
		oe = '0;
		wr_do = 1'b0;
		// pins and the count input pass two flops before any logic reads them
		s_nxt.pre = s_r.pre + 8'h1;
		s_nxt.syn1 = cc_pin_in;
		s_nxt.syn2 = s_r.syn1;
		s_nxt.syn3 = s_r.syn2;
		s_nxt.ext = {s_r.ext[1:0], ext_count};

		// time bases
		for (int b = 0; b < 2; b++) begin
			sel = s_r.ctrl[ccu_pkg::CCU_SEL_A + ccu_pkg::CCU_TB_STEP*b +: 3];
			pmask = (8'h1 << sel) - 8'h1;
			if (sel == ccu_pkg::CCU_SEL_OVF)
				src = upstream_ovf;
			else if (sel == ccu_pkg::CCU_SEL_EXT)
				src = s_r.ext[1] & ~s_r.ext[2];
			else
				src = (s_r.pre & pmask) == pmask;
			// staggered: only one prescaler phase in eight may tick; external
			// events falling on another phase are lost
			if (s_r.ctrl[ccu_pkg::CCU_STAGGER])
				src = src & (s_r.pre[2:0] == ccu_pkg::CCU_STAG_PH);
			tk[b] = s_r.ctrl[ccu_pkg::CCU_RUN_A + ccu_pkg::CCU_TB_STEP*b] & src;
			ovf[b] = tk[b] && s_r.tmr[b] == ccu_pkg::CCU_TMR_TOP;
			s_nxt.tick_d[b] = tk[b];
			if (ovf[b])
				s_nxt.tmr[b] = s_r.rld[b];
			else if (tk[b])
				s_nxt.tmr[b] = s_r.tmr[b] + 16'h1;
		end

		// channel array
		for (int i = 0; i < NCH; i++) begin
			md = ccu_pkg::ccu_mode_t'(s_r.cfg[i][2:0]);
			tb = s_r.cfg[i][ccu_pkg::CCU_CFG_TB];
			rise = s_r.syn2[i] & ~s_r.syn3[i];
			fall = ~s_r.syn2[i] & s_r.syn3[i];
			s_nxt.irq[i] = 1'b0;
			trig[i] = md == ccu_pkg::CCU_CAP && ((s_r.cfg[i][ccu_pkg::CCU_EDGE_R] & rise) |
				(s_r.cfg[i][ccu_pkg::CCU_EDGE_F] & fall));
			if (trig[i]) begin
				s_nxt.val[i] = s_r.tmr[tb];
				s_nxt.irq[i] = 1'b1;
			end
			// a match counts once per timer step, not while the timer stands
			hit = md >= ccu_pkg::CCU_CMP0 && md <= ccu_pkg::CCU_CMP3 && s_r.tick_d[tb] &&
				s_r.tmr[tb] == s_r.val[i] && !s_r.done[i];
			act[i] = hit && !((md == ccu_pkg::CCU_CMP2 || md == ccu_pkg::CCU_CMP3) &&
				s_r.fired[i]);
			if (ovf[tb]) begin
				s_nxt.fired[i] = 1'b0;
				if (md == ccu_pkg::CCU_CMP3)
					s_nxt.pin[i] = 1'b0;
			end
			// set after the overflow clear, so a match in the same cycle wins
			if (act[i]) begin
				s_nxt.fired[i] = 1'b1;
				s_nxt.done[i] = s_r.cfg[i][ccu_pkg::CCU_SINGLE];
				s_nxt.irq[i] = 1'b1;
				if (md == ccu_pkg::CCU_CMP1)
					s_nxt.pin[i] = ~s_r.pin[i];
				if (md == ccu_pkg::CCU_CMP3)
					s_nxt.pin[i] = 1'b1;
			end
			oe[i] = md == ccu_pkg::CCU_CMP1 || md == ccu_pkg::CCU_CMP3;
		end
		// upper-half channel i+HALF toggles lower pin i when paired
		for (int i = 0; i < HALF; i++) begin
			if (s_r.cfg[i][ccu_pkg::CCU_DBL]) begin
				oe[i] = 1'b1;
				if (act[i+HALF])
					s_nxt.pin[i] = ~s_nxt.pin[i];
			end
		end

		// bus slave: address and data taken in either order
		if (awvalid && !s_r.aw_got) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = awaddr;
		end
		if (wvalid && !s_r.w_got) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = wdata;
			s_nxt.wstrb = wstrb;
		end
		if (s_r.bvalid && bready)
			s_nxt.bvalid = 1'b0;
		wr_do = s_r.aw_got && s_r.w_got && !s_r.bvalid;
		if (wr_do) begin
			rr = ccu_rd(s_r, wa);
			mw = ccu_merge(rr[31:0], s_r.wdata, s_r.wstrb);
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = rr[32] ? ccu_pkg::CCU_OKAY : ccu_pkg::CCU_SLVERR;
			// software writes land after the count update and win over it
			if (wa == ccu_pkg::CCU_CTRL)
				s_nxt.ctrl = mw & ccu_pkg::CCU_CTRL_MSK;
			else if (wa == ccu_pkg::CCU_TMR_A)
				s_nxt.tmr[0] = mw[15:0];
			else if (wa == ccu_pkg::CCU_RLD_A)
				s_nxt.rld[0] = mw[15:0];
			else if (wa == ccu_pkg::CCU_TMR_B)
				s_nxt.tmr[1] = mw[15:0];
			else if (wa == ccu_pkg::CCU_RLD_B)
				s_nxt.rld[1] = mw[15:0];
			else if (rr[32] && wa[11:6] == ccu_pkg::CCU_CFG_BASE[11:6]) begin
				s_nxt.cfg[wa[5:2]] = mw[7:0];
				s_nxt.fired[wa[5:2]] = s_nxt.fired[wa[5:2]] & act[wa[5:2]];
				s_nxt.done[wa[5:2]] = s_nxt.done[wa[5:2]] & act[wa[5:2]];
			end else if (rr[32])
				s_nxt.val[wa[5:2]] = mw[15:0];
		end
		if (s_r.rvalid && rready)
			s_nxt.rvalid = 1'b0;
		if (arvalid && !s_r.rvalid) begin
			rr = ccu_rd(s_r, {araddr[11:2], 2'b00});
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rr[31:0];
			s_nxt.rresp = rr[32] ? ccu_pkg::CCU_OKAY : ccu_pkg::CCU_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign awready    = !s_r.aw_got;
	assign wready     = !s_r.w_got;
	assign bvalid     = s_r.bvalid;
	assign bresp      = s_r.bresp;
	assign arready    = !s_r.rvalid;
	assign rvalid     = s_r.rvalid;
	assign rdata      = s_r.rdata;
	assign rresp      = s_r.rresp;
	assign cc_pin_out = s_r.pin;
	assign cc_pin_oe  = oe;
	assign cc_irq     = s_r.irq;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_inc;
		tk[0] && !ovf[0] && !wr_do |=> s_r.tmr[0] == $past(s_r.tmr[0]) + 16'h1;
	endproperty
	a_inc: assert property (p_inc) else $error("timer a did not advance");

	property p_reload;
		ovf[0] && !wr_do |=> s_r.tmr[0] == $past(s_r.rld[0]) && s_r.tick_d[0];
	endproperty
	a_reload: assert property (p_reload) else $error("timer a missed reload");

	property p_hold;
		!s_r.ctrl[ccu_pkg::CCU_RUN_A] && !wr_do |=> $stable(s_r.tmr[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("stopped timer moved");

	property p_stagger;
		s_r.ctrl[ccu_pkg::CCU_STAGGER] && tk[1] |-> s_r.pre[2:0] == ccu_pkg::CCU_STAG_PH;
	endproperty
	a_stagger: assert property (p_stagger) else $error("staggered tick off phase");

	property p_capture;
		trig[6] && !wr_do |=> s_r.val[6] == $past(s_r.tmr[s_r.cfg[6][ccu_pkg::CCU_CFG_TB]])
			&& s_r.irq[6];
	endproperty
	a_capture: assert property (p_capture) else $error("capture lost");

	property p_edge;
		s_r.cfg[6][2:0] == ccu_pkg::CCU_CAP && s_r.syn2[6] == s_r.syn3[6] |=> !s_r.irq[6];
	endproperty
	a_edge: assert property (p_edge) else $error("capture without edge");

	property p_match;
		s_r.cfg[0][2:0] == ccu_pkg::CCU_CMP0 && s_r.tick_d[0] && !s_r.cfg[0][ccu_pkg::CCU_CFG_TB] &&
			s_r.tmr[0] == s_r.val[0] && !s_r.done[0] |-> act[0] ##1 s_r.irq[0];
	endproperty
	a_match: assert property (p_match) else $error("mode 0 match missed");

	property p_toggle;
		act[1] && s_r.cfg[1][2:0] == ccu_pkg::CCU_CMP1 &&
			!(s_r.cfg[1][ccu_pkg::CCU_DBL] && act[1+HALF]) |=> s_r.pin[1] != $past(s_r.pin[1]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("mode 1 pin not toggled");

	property p_once;
		s_r.fired[2] && s_r.cfg[2][2:0] == ccu_pkg::CCU_CMP2 |-> !act[2];
	endproperty
	a_once: assert property (p_once) else $error("second mode 2 match");

	property p_mode3;
		act[3] && s_r.cfg[3][2:0] == ccu_pkg::CCU_CMP3 && !wr_do |=> s_r.pin[3] ##1 1'b1;
	endproperty
	a_mode3: assert property (p_mode3) else $error("mode 3 pin not set");

	property p_dbl;
		s_r.cfg[0][ccu_pkg::CCU_DBL] && act[HALF] && !act[0] && s_r.cfg[0][2:0] !=
			ccu_pkg::CCU_CMP3 |=> s_r.pin[0] != $past(s_r.pin[0]);
	endproperty
	a_dbl: assert property (p_dbl) else $error("paired match did not toggle");

	property p_single;
		s_r.done[4] |-> !act[4];
	endproperty
	a_single: assert property (p_single) else $error("single event repeated");
endmodule

// ==== ccu_far_side.sv ====
// far-side model: upstream timer overflow, external count input and pin pads
module ccu_far_side (
	input  wire logic        aclk,
	input  wire logic        ovf_kick,
	input  wire logic        ext_lvl,
	input  wire logic [15:0] pin_drv,
	input  wire logic [15:0] cc_pin_out,
	input  wire logic [15:0] cc_pin_oe,
	output logic             upstream_ovf,
	output logic             ext_count,
	output logic [15:0]      cc_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// upstream timer: one-cycle overflow pulse on the unit's own clock
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		upstream_ovf <= ovf_kick;
	end
	assign ext_count = ext_lvl;
	// ---------------------------------------------------------------
	// pads: the unit wins wherever it drives the pin
	// ---------------------------------------------------------------
	assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & pin_drv);
endmodule

// ==== ccu_capture_compare_unit_tb.sv ====
// self-checking bench for the capture/compare unit
module ccu_capture_compare_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        bready = 1'b1, rready = 1'b1;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        ovf_kick = 1'b0, ext_lvl = 1'b0;
	logic [15:0] pin_drv = 16'h0;
	logic        awready, wready, bvalid, arready, rvalid, upstream_ovf, ext_count;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] cc_pin_in, cc_pin_out, cc_pin_oe, cc_irq, rnd_b;
	logic [33:0] exp_q[$], seen_v;
	string       name_q[$];
	int          miscompares = 0, n_tests = 0;
	logic [7:0]  cfg_tab [9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h42, 8'h00, 8'h09, 8'h31, 8'h19};
	logic [15:0] val_tab [5] = '{16'hfffd, 16'hfffe, 16'hfffd, 16'hfffe, 16'hffff};

	always #20 aclk = ~aclk;

	ccu_capture_compare_unit #(.NCH(16)) ccu_capture_compare_unit_inst (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .upstream_ovf(upstream_ovf),
		.ext_count(ext_count), .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out),
		.cc_pin_oe(cc_pin_oe), .cc_irq(cc_irq)
	);
	ccu_far_side ccu_far_side_inst (
		.aclk(aclk), .ovf_kick(ovf_kick), .ext_lvl(ext_lvl), .pin_drv(pin_drv),
		.cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .upstream_ovf(upstream_ovf),
		.ext_count(ext_count), .cc_pin_in(cc_pin_in)
	);

	// ---------------------------------------------------------------
	// checking and closing
	// ---------------------------------------------------------------
	task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic expect_note(input string nm, input logic [33:0] v);
		name_q.push_back(nm);
		exp_q.push_back(v);
	endtask
	task automatic report_and_stop;
		if (exp_q.size() != 0) begin
			miscompares++;
			$display("[ERR] events expected %0d more seen none", exp_q.size());
		end
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// a read answer, a write response or an interrupt pulse consumes the oldest note
	always @(posedge aclk) begin
		seen_v = rvalid ? {rresp, rdata} : bvalid ? {bresp, 32'h0} : {2'h0, cc_pin_out, cc_irq};
		if (aresetn && (rvalid || bvalid || cc_irq !== 16'h0)) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("[ERR] event expected none seen %h", seen_v);
			end else begin
				check(name_q.pop_front(), seen_v, exp_q.pop_front());
			end
		end
	end

	// ---------------------------------------------------------------
	// bus master and stimulus tasks
	// ---------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
			input logic [1:0] er = ccu_pkg::CCU_OKAY);
		expect_note("bresp", {er, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [33:0] v);
		expect_note(nm, v);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
	endtask
	// one upstream overflow pulse; v is the expected pin and request pattern
	task automatic tick(input logic [31:0] v);
		if (v !== 32'h0) expect_note("pins_irq", {2'h0, v});
		ovf_kick <= 1'b1;
		@(posedge aclk);
		ovf_kick <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		$display("[ERR] watchdog expected done seen hang");
		report_and_stop();
	end

	initial begin
		void'($urandom(32'h180c6979));
		rnd_b = 16'($urandom()) & 16'h7fff;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd("ctrl", ccu_pkg::CCU_CTRL, 34'h0);
		rd("tmr_a", ccu_pkg::CCU_TMR_A, 34'h0);
		wr(ccu_pkg::CCU_CTRL, 32'hffff_ffff);
		rd("ctrl", ccu_pkg::CCU_CTRL, {2'h0, ccu_pkg::CCU_CTRL_MSK});
		wr(ccu_pkg::CCU_CTRL, 32'h0);
		rd("hole", 12'h0fc, {ccu_pkg::CCU_SLVERR, 32'h0});
		wr(12'h0fc, 32'hffff_ffff, ccu_pkg::CCU_SLVERR);
		wr(ccu_pkg::CCU_RLD_A, 32'h0000_fffc);
		rd("rld_a", ccu_pkg::CCU_RLD_A, 34'h0_0000_fffc);
		wr(ccu_pkg::CCU_TMR_A, 32'h0000_fffc);
		wr(ccu_pkg::CCU_TMR_B, {16'h0, rnd_b});
		for (int i = 0; i < 9; i++) begin
			wr(ccu_pkg::CCU_CFG_BASE + 12'(4 * i), {24'h0, cfg_tab[i]});
			if (i < 5) wr(ccu_pkg::CCU_VAL_BASE + 12'(4 * i), {16'h0, val_tab[i]});
		end
		rd("cfg7", ccu_pkg::CCU_CFG_BASE + 12'h01c, 34'h31);
		// time base a counts upstream overflows, period fffc..ffff
		wr(ccu_pkg::CCU_CTRL, 32'h0000_000d);
		tick(32'h0000_0005);
		tick(32'h000a_000a);
		tick(32'h000a_0010);
		// rewind without overflow: once-per-period modes stay quiet
		wr(ccu_pkg::CCU_TMR_A, 32'h0000_fffc);
		tick(32'h000a_0001);
		tick(32'h0008_0002);
		tick(32'h0);
		tick(32'h0);
		tick(32'h0000_0005);
		tick(32'h000a_000a);
		tick(32'h0);
		rd("tmr_a", ccu_pkg::CCU_TMR_A, 34'h0_0000_ffff);
		// captures: ch6 rising, ch7 falling on time base b, ch8 both edges
		expect_note("pins_irq", 34'h0_000a_0140);
		pin_drv <= 16'h01c0;
		repeat (8) @(posedge aclk);
		expect_note("pins_irq", 34'h0_000a_0180);
		pin_drv <= 16'h0000;
		repeat (8) @(posedge aclk);
		rd("cap6", ccu_pkg::CCU_VAL_BASE + 12'h018, 34'h0_0000_ffff);
		rd("cap7", ccu_pkg::CCU_VAL_BASE + 12'h01c, {18'h0, rnd_b});
		rd("cap8", ccu_pkg::CCU_VAL_BASE + 12'h020, 34'h0_0000_ffff);
		// time base b counts external rising edges
		wr(ccu_pkg::CCU_CTRL, 32'h0000_0f0d);
		repeat (3) begin
			ext_lvl <= 1'b1;
			repeat (6) @(posedge aclk);
			ext_lvl <= 1'b0;
			repeat (6) @(posedge aclk);
		end
		rd("tmr_b", ccu_pkg::CCU_TMR_B, {18'h0, rnd_b + 16'h3});
		// prescale 2, then staggered: any 64 cycles give 32, then 8 ticks on time base b
		wr(ccu_pkg::CCU_CTRL, 32'h0000_0300);
		wr(ccu_pkg::CCU_TMR_B, {16'h0, rnd_b});
		repeat (63) @(posedge aclk);
		rd("tmr_b", ccu_pkg::CCU_TMR_B, {18'h0, rnd_b + 16'h20});
		wr(ccu_pkg::CCU_CTRL, 32'h0001_0300);
		wr(ccu_pkg::CCU_TMR_B, {16'h0, rnd_b});
		repeat (63) @(posedge aclk);
		rd("tmr_b", ccu_pkg::CCU_TMR_B, {18'h0, rnd_b + 16'h8});
		// double register: ch8 matches toggle pin 0 next to ch0's own mode 1 toggles
		wr(ccu_pkg::CCU_CTRL, 32'h0000_000d);
		wr(ccu_pkg::CCU_CFG_BASE, 32'h0000_0083);
		wr(ccu_pkg::CCU_CFG_BASE + 12'h020, 32'h0000_0002);
		wr(ccu_pkg::CCU_VAL_BASE + 12'h020, 32'h0000_fffe);
		tick(32'h0);
		tick(32'h0003_0005);
		tick(32'h0008_010a);
		repeat (4) @(posedge aclk);
		report_and_stop();
	end
endmodule
